/* File: rtl/hpsc_if.sv */
`timescale 1ns/1ns
interface hpsc_if;
  import hpsc_pkg::*;
  logic [NPIN-1:0] raw;
  logic [NPIN-1:0] lvl;
  logic [NPIN-1:0] chg;
  modport src (input raw, output lvl, output chg);
  modport dst (output raw, input lvl, input chg);
endinterface : hpsc_if

/* File: rtl/hpsc_pkg.sv */
// Contract
// - Control bit 0, reset 0, enables attention-button-press interrupts.
// - Control bit 1, reset 0, enables power-fault interrupts.
// - Control bit 3 enables presence-detect-changed interrupts.
// - Control bit 4, reset 0, enables command-completed interrupts.
// - Control bit 5, reset 0, is the master hot-plug interrupt enable.
// - Control bits 7:6 drive attention indicator: 01 on, 10 blink, 11 off; reset 11.
// - Any write of the attention field sends an attention indicator message.
// - Control bits 9:8 drive power indicator, same coding, reset 11, message per write.
// - Control bit 10 commands slot power: 0 on, 1 off; reset 0.
// - Status bit 16 sets on button press; reset 0; write one clears.
// - Status bit 17 sets on power fault; reset 0; write one clears.
// - Status bit 18 reports a latch sensor change; read-only; reset 0.
// - Status bit 19 sets on card presence change; reset 0; write one clears.
// - Status bit 20 sets when a slot command completes; write one clears.
// - Status bit 21 shows live latch sensor: 0 closed, 1 open; reset 0.
// - Status bit 22 shows card presence: 0 empty, 1 present; read-only.
// - Presence state resets to the inverse of the presence strap.
// - Status bit 24 sets on link-active change; write one clears; enable bit 12.
// - Link-active input is 1 only in the link layer active state.
package hpsc_pkg;
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  SLOT_OFS    = 8'hD8;
  localparam int unsigned CTL_ABP_EN  = 0;
  localparam int unsigned CTL_PFD_EN  = 1;
  localparam int unsigned CTL_PDC_EN  = 3;
  localparam int unsigned CTL_CC_EN   = 4;
  localparam int unsigned CTL_HPI_EN  = 5;
  localparam int unsigned CTL_AI_LO   = 6;
  localparam int unsigned CTL_PI_LO   = 8;
  localparam int unsigned CTL_PWR_OFF = 10;
  localparam int unsigned CTL_DLL_EN  = 12;
  localparam int unsigned ST_ABP      = 16;
  localparam int unsigned ST_PFD      = 17;
  localparam int unsigned ST_LCH      = 18;
  localparam int unsigned ST_PDC      = 19;
  localparam int unsigned ST_CC       = 20;
  localparam int unsigned ST_LST      = 21;
  localparam int unsigned ST_PDS      = 22;
  localparam int unsigned ST_DLL      = 24;
  localparam logic [15:0] CTL_WMASK   = 16'h17FB;
  localparam logic [15:0] CTL_RST     = 16'h03C0;
  localparam logic [31:0] ST_W1C_MASK = 32'h011B_0000;
  localparam logic [31:0] RD_MASK     = 32'h017F_17FB;
  localparam logic [1:0]  IND_ON      = 2'h1;
  localparam logic [1:0]  IND_BLINK   = 2'h2;
  localparam logic [1:0]  IND_OFF     = 2'h3;
  localparam int unsigned NPIN        = 4;
  localparam int unsigned PIN_BTN     = 0;
  localparam int unsigned PIN_PF      = 1;
  localparam int unsigned PIN_LAT     = 2;
  localparam int unsigned PIN_PRS     = 3;

  typedef struct packed {
    logic [15:0] ctl;
    logic        abp;
    logic        pfd;
    logic        lch;
    logic        pdc;
    logic        cc;
    logic        dll;
    logic        pres;
    logic        init;
    logic        link_prev;
    logic        irq;
    logic        attn_vld;
    logic        pwr_vld;
    logic [31:0] rdat;
  } hpsc_state_t;
endpackage : hpsc_pkg

/* File: rtl/hpsc_slot_regs.sv */
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
module hpsc_slot_regs (
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  input  wire logic [hpsc_pkg::ADDR_W-1:0] addr,
  input  wire logic [31:0]               wr_data,
  input  wire logic                      wr_en,
  input  wire logic                      rd_en,
  output logic [31:0]                    rd_data,
  input  wire logic                      attn_button,
  input  wire logic                      power_fault,
  input  wire logic                      retention_latch_sensor,
  input  wire logic                      card_present,
  input  wire logic                      presence_strap,
  input  wire logic                      slot_implemented,
  input  wire logic                      link_layer_active_state,
  input  wire logic                      cmd_done,
  output logic [1:0]                     attn_ind,
  output logic [1:0]                     pwr_ind,
  output logic                           pwr_off,
  output logic                           attn_msg_vld,
  output logic [1:0]                     attn_msg_code,
  output logic                           pwr_msg_vld,
  output logic [1:0]                     pwr_msg_code,
  output logic                           hp_irq
);
  import hpsc_pkg::*;

  hpsc_if      sif ();
  hpsc_state_t cur_ff;
  hpsc_state_t nxt_cur;

  assign sif.raw[PIN_BTN] = attn_button;
  assign sif.raw[PIN_PF]  = power_fault;
  assign sif.raw[PIN_LAT] = retention_latch_sensor;
  assign sif.raw[PIN_PRS] = card_present;

  hpsc_sync u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .sif    (sif.src)
  );

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a == SLOT_OFS);
  endfunction : addr_hit

  function automatic logic [31:0] read_word(input hpsc_state_t s,
                                            input logic        lat,
                                            input logic        impl);
    logic [31:0] w;
    w         = '0;
    w[15:0]   = s.ctl & CTL_WMASK;
    w[ST_ABP] = s.abp;
    w[ST_PFD] = s.pfd;
    w[ST_LCH] = s.lch;
    w[ST_PDC] = s.pdc;
    w[ST_CC]  = s.cc;
    w[ST_LST] = lat;
    // no slot behind the port: report a card as always present
    // forced presence
    w[ST_PDS] = impl ? s.pres : 1'b1;
    w[ST_DLL] = s.dll;
    read_word = w & RD_MASK;
  endfunction : read_word

  logic        wr;
  logic        rd;
  logic [31:0] w1c;
  logic        ev_btn;
  logic        ev_pf;
  logic        ev_lat;
  logic        ev_prs;
  logic        ev_link;

  always_comb begin
    wr      = wr_en && addr_hit(addr);
    rd      = rd_en && addr_hit(addr);
    w1c     = wr ? (wr_data & ST_W1C_MASK) : '0;
    ev_btn  = sif.chg[PIN_BTN] && sif.lvl[PIN_BTN];
    ev_pf   = sif.chg[PIN_PF] && sif.lvl[PIN_PF];
    ev_lat  = sif.chg[PIN_LAT];
    ev_prs  = cur_ff.init && sif.chg[PIN_PRS] && (sif.lvl[PIN_PRS] != cur_ff.pres);
    // link active change
    // init stays low until the first edge, so no change is seen there whatever link_prev holds
    ev_link = cur_ff.init && (link_layer_active_state != cur_ff.link_prev);

    nxt_cur           = cur_ff;
    nxt_cur.link_prev = link_layer_active_state;

    if (wr) begin
      nxt_cur.ctl = wr_data[15:0] & CTL_WMASK;
    end
    // every write carries both indicator fields, so both messages go out
    // attention message
    nxt_cur.attn_vld = wr;
    nxt_cur.pwr_vld  = wr;

    // strap is sampled on the first clock after reset release, not in reset
    // strap seeds presence
    if (!cur_ff.init) begin
      nxt_cur.init = 1'b1;
      nxt_cur.pres = ~presence_strap;
    end else if (sif.chg[PIN_PRS]) begin
      nxt_cur.pres = sif.lvl[PIN_PRS];
    end

    // a new event in the clearing cycle wins over the clear
    // button flag
    nxt_cur.abp = (cur_ff.abp & ~w1c[ST_ABP]) | ev_btn;
    nxt_cur.pfd = (cur_ff.pfd & ~w1c[ST_PFD]) | ev_pf;
    nxt_cur.lch = cur_ff.lch | ev_lat;
    nxt_cur.pdc = (cur_ff.pdc & ~w1c[ST_PDC]) | ev_prs;
    nxt_cur.cc  = (cur_ff.cc & ~w1c[ST_CC]) | cmd_done;
    nxt_cur.dll = (cur_ff.dll & ~w1c[ST_DLL]) | ev_link;

    nxt_cur.irq = nxt_cur.ctl[CTL_HPI_EN] &
                  ((nxt_cur.abp & nxt_cur.ctl[CTL_ABP_EN]) |
                   (nxt_cur.pfd & nxt_cur.ctl[CTL_PFD_EN]) |
                   (nxt_cur.pdc & nxt_cur.ctl[CTL_PDC_EN]) |
                   (nxt_cur.cc  & nxt_cur.ctl[CTL_CC_EN])  |
                   (nxt_cur.dll & nxt_cur.ctl[CTL_DLL_EN]));

    nxt_cur.rdat = rd ? read_word(cur_ff, sif.lvl[PIN_LAT], slot_implemented) : '0;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff     <= '0;
      cur_ff.ctl <= CTL_RST;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign rd_data       = cur_ff.rdat;
  assign attn_ind      = cur_ff.ctl[CTL_AI_LO +: 2];
  assign pwr_ind       = cur_ff.ctl[CTL_PI_LO +: 2];
  assign pwr_off       = cur_ff.ctl[CTL_PWR_OFF];
  assign attn_msg_vld  = cur_ff.attn_vld;
  assign attn_msg_code = cur_ff.ctl[CTL_AI_LO +: 2];
  assign pwr_msg_vld   = cur_ff.pwr_vld;
  assign pwr_msg_code  = cur_ff.ctl[CTL_PI_LO +: 2];
  assign hp_irq        = cur_ff.irq;

  AST_ATTN_MSG: assert property (
    @(posedge clk) disable iff (!arst_n)
    (wr_en && addr == SLOT_OFS)
    |=> attn_msg_vld && attn_msg_code == $past(wr_data[7:6]))
    else $error("attention message missing after write");

  AST_PWR_MSG: assert property (
    @(posedge clk) disable iff (!arst_n)
    (wr_en && addr == SLOT_OFS)
    |=> pwr_msg_vld && pwr_msg_code == $past(wr_data[9:8]))
    else $error("power message missing after write");

  AST_NO_MSG: assert property (
    @(posedge clk) disable iff (!arst_n)
    !(wr_en && addr == SLOT_OFS)
    |=> !attn_msg_vld && !pwr_msg_vld)
    else $error("indicator message without a write");

  AST_PWR_CTRL: assert property (
    @(posedge clk) disable iff (!arst_n)
    (wr_en && addr == SLOT_OFS)
    |=> pwr_off == $past(wr_data[10]))
    else $error("power control not updated");

  AST_MASTER_OFF: assert property (
    @(posedge clk) disable iff (!arst_n)
    !nxt_cur.ctl[CTL_HPI_EN]
    |=> !hp_irq)
    else $error("interrupt without master enable");

  AST_BTN_IRQ: assert property (
    @(posedge clk) disable iff (!arst_n)
    (cur_ff.abp && cur_ff.ctl[CTL_ABP_EN] && cur_ff.ctl[CTL_HPI_EN])
    |-> hp_irq)
    else $error("enabled button flag did not raise interrupt");

  AST_BTN_SET: assert property (
    @(posedge clk) disable iff (!arst_n)
    ev_btn
    |=> cur_ff.abp)
    else $error("button flag not set");

  AST_W1C: assert property (
    @(posedge clk) disable iff (!arst_n)
    (cur_ff.pfd && wr && !wr_data[ST_PFD])
    |=> cur_ff.pfd)
    else $error("zero write cleared fault flag");

  AST_CLEAR: assert property (
    @(posedge clk) disable iff (!arst_n)
    (wr && wr_data[ST_PFD] && !ev_pf)
    |=> !cur_ff.pfd)
    else $error("write one did not clear fault flag");

  AST_LINK: assert property (
    @(posedge clk) disable iff (!arst_n)
    (cur_ff.init && $changed(link_layer_active_state))
    |=> cur_ff.dll)
    else $error("link change not flagged");

  AST_RSVD: assert property (
    @(posedge clk) disable iff (!arst_n)
    (rd_data & ~RD_MASK) == '0)
    else $error("reserved bits read nonzero");

  AST_NOSLOT: assert property (
    @(posedge clk) disable iff (!arst_n)
    (rd && !slot_implemented)
    |=> rd_data[ST_PDS])
    else $error("presence not forced with no slot");

  AST_PFD_SET: assert property (
    @(posedge clk) disable iff (!arst_n)
    ev_pf
    |=> cur_ff.pfd)
    else $error("fault flag not set");

  AST_PDC_SET: assert property (
    @(posedge clk) disable iff (!arst_n)
    ev_prs
    |=> cur_ff.pdc)
    else $error("presence change flag not set");

  AST_CC_SET: assert property (
    @(posedge clk) disable iff (!arst_n)
    cmd_done
    |=> cur_ff.cc)
    else $error("command completed flag not set");

  AST_LCH_SET: assert property (
    @(posedge clk) disable iff (!arst_n)
    ev_lat
    |=> cur_ff.lch)
    else $error("latch change flag not set");

  AST_LCH_STICKY: assert property (
    @(posedge clk) disable iff (!arst_n)
    cur_ff.lch
    |=> cur_ff.lch)
    else $error("latch change flag dropped");

  AST_BTN_CLEAR: assert property (
    @(posedge clk) disable iff (!arst_n)
    (w1c[ST_ABP] && !ev_btn)
    |=> !cur_ff.abp)
    else $error("write one did not clear button flag");

  AST_PDC_CLEAR: assert property (
    @(posedge clk) disable iff (!arst_n)
    (w1c[ST_PDC] && !ev_prs)
    |=> !cur_ff.pdc)
    else $error("write one did not clear presence change flag");

  AST_CC_CLEAR: assert property (
    @(posedge clk) disable iff (!arst_n)
    (w1c[ST_CC] && !cmd_done)
    |=> !cur_ff.cc)
    else $error("write one did not clear command completed flag");

  AST_DLL_CLEAR: assert property (
    @(posedge clk) disable iff (!arst_n)
    (w1c[ST_DLL] && !ev_link)
    |=> !cur_ff.dll)
    else $error("write one did not clear link change flag");

  AST_BTN_KEEP: assert property (
    @(posedge clk) disable iff (!arst_n)
    (cur_ff.abp && !w1c[ST_ABP])
    |=> cur_ff.abp)
    else $error("button flag lost without write one");

  AST_PDC_KEEP: assert property (
    @(posedge clk) disable iff (!arst_n)
    (cur_ff.pdc && !w1c[ST_PDC])
    |=> cur_ff.pdc)
    else $error("presence change flag lost without write one");

  AST_CC_KEEP: assert property (
    @(posedge clk) disable iff (!arst_n)
    (cur_ff.cc && !w1c[ST_CC])
    |=> cur_ff.cc)
    else $error("command completed flag lost without write one");

  AST_DLL_KEEP: assert property (
    @(posedge clk) disable iff (!arst_n)
    (cur_ff.dll && !w1c[ST_DLL])
    |=> cur_ff.dll)
    else $error("link change flag lost without write one");

  AST_RD_IDLE: assert property (
    @(posedge clk) disable iff (!arst_n)
    !rd
    |=> rd_data == '0)
    else $error("read data without a mapped read");

  AST_CTL_HOLD: assert property (
    @(posedge clk) disable iff (!arst_n)
    !wr
    |=> $stable(cur_ff.ctl))
    else $error("control changed without a mapped write");

  AST_CTL_RSVD: assert property (
    @(posedge clk) disable iff (!arst_n)
    (cur_ff.ctl & ~CTL_WMASK) == 16'h0000)
    else $error("reserved control bits set");

  AST_LIVE_LATCH: assert property (
    @(posedge clk) disable iff (!arst_n)
    rd
    |=> rd_data[ST_LST] == $past(sif.lvl[PIN_LAT]))
    else $error("latch state not live");

  AST_PRES_RD: assert property (
    @(posedge clk) disable iff (!arst_n)
    (rd && slot_implemented)
    |=> rd_data[ST_PDS] == $past(cur_ff.pres))
    else $error("presence state not reported");

  AST_STRAP: assert property (
    @(posedge clk) disable iff (!arst_n)
    !cur_ff.init
    |=> cur_ff.pres != $past(presence_strap))
    else $error("presence state not seeded from strap");

  AST_IRQ_EQ: assert property (
    @(posedge clk) disable iff (!arst_n)
    hp_irq == (cur_ff.ctl[CTL_HPI_EN] &&
               ((cur_ff.abp && cur_ff.ctl[CTL_ABP_EN]) ||
                (cur_ff.pfd && cur_ff.ctl[CTL_PFD_EN]) ||
                (cur_ff.pdc && cur_ff.ctl[CTL_PDC_EN]) ||
                (cur_ff.cc && cur_ff.ctl[CTL_CC_EN]) ||
                (cur_ff.dll && cur_ff.ctl[CTL_DLL_EN]))))
    else $error("interrupt does not match enabled flags");

  COV_IRQ:   cover property (@(posedge clk) disable iff (!arst_n) $rose(hp_irq));
  COV_CLR:   cover property (@(posedge clk) disable iff (!arst_n) $fell(cur_ff.abp));
  COV_RACE:  cover property (@(posedge clk) disable iff (!arst_n) ev_btn && w1c[ST_ABP]);
  COV_PRES:  cover property (@(posedge clk) disable iff (!arst_n) ev_prs);
endmodule : hpsc_slot_regs

/* File: rtl/hpsc_sync.sv */
`timescale 1ns/1ns
module hpsc_sync (
  input  wire logic clk,
  input  wire logic arst_n,
  hpsc_if.src       sif
);
  import hpsc_pkg::*;

  typedef struct packed {
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [NPIN-1:0] lvl;
    logic [NPIN-1:0] chg;
  } hpsc_sync_t;

  hpsc_sync_t cur_ff;
  hpsc_sync_t nxt_cur;

  always_comb begin
    nxt_cur     = cur_ff;
    nxt_cur.s1  = sif.raw;
    nxt_cur.s2  = cur_ff.s1;
    nxt_cur.s3  = cur_ff.s2;
    nxt_cur.chg = '0;
    // s1 feeds s2 only; stages 2 and 3 must agree before a level is taken
    for (int i = 0; i < NPIN; i++) begin
      if (cur_ff.s2[i] == cur_ff.s3[i] && cur_ff.s3[i] != cur_ff.lvl[i]) begin
        nxt_cur.lvl[i] = cur_ff.s3[i];
        nxt_cur.chg[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign sif.lvl = cur_ff.lvl;
  assign sif.chg = cur_ff.chg;
endmodule : hpsc_sync

/* File: tb/hpsc_slot_model.sv */
`timescale 1ns/1ns
module hpsc_slot_model #(
  parameter int CMD_LAT = 2
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic pwr_off,
  output logic      attn_button,
  output logic      power_fault,
  output logic      retention_latch_sensor,
  output logic      card_present,
  output logic      cmd_done
);
  logic       pwr_prev_ff;
  logic [3:0] cnt_ff;
  // sensors start settled with a card seated; the bench moves them
  initial begin
    attn_button = 1'h0;
    power_fault = 1'h0;
    retention_latch_sensor = 1'h0;
    card_present = 1'h1;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_prev_ff <= 1'h0;
      cnt_ff <= 4'h0;
      cmd_done <= 1'h0;
    end else begin
      pwr_prev_ff <= pwr_off;
      cmd_done <= (cnt_ff == 4'h1);
      if (pwr_off != pwr_prev_ff) cnt_ff <= 4'(CMD_LAT);
      else if (cnt_ff != 4'h0) cnt_ff <= cnt_ff - 4'h1;
    end
  end
endmodule : hpsc_slot_model

/* File: tb/tb_hpsc_slot_regs.sv */
`timescale 1ns/1ns
module tb_hpsc_slot_regs;
  import hpsc_pkg::*;
  logic        clk, arst_n, wr_en, rd_en, strap, impl, link, btn, pf, lat, card, done;
  logic        pwr_off, attn_vld, pwr_vld, hp_irq;
  logic [1:0]  attn_ind, pwr_ind, attn_code, pwr_code;
  logic [7:0]  addr;
  logic [31:0] wr_data, rd_data, word;
  int          mismatches, comparisons, cycles;
  int          bits[4] = '{16, 17, 19, 24};
  hpsc_slot_regs dut_u (.clk(clk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .attn_button(btn), .power_fault(pf),
    .retention_latch_sensor(lat), .card_present(card), .presence_strap(strap),
    .slot_implemented(impl), .link_layer_active_state(link), .cmd_done(done),
    .attn_ind(attn_ind), .pwr_ind(pwr_ind), .pwr_off(pwr_off), .attn_msg_vld(attn_vld),
    .attn_msg_code(attn_code), .pwr_msg_vld(pwr_vld), .pwr_msg_code(pwr_code),
    .hp_irq(hp_irq));
  hpsc_slot_model slot_u (.clk(clk), .arst_n(arst_n), .pwr_off(pwr_off), .attn_button(btn),
    .power_fault(pf), .retention_latch_sensor(lat), .card_present(card), .cmd_done(done));
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'h1;
    @(posedge clk);
    wr_en <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    #1 word = rd_data;
  endtask : rd
  task automatic irq_is(input logic exp, input int n);
    idle(n);
    #1 check("hp_irq", {31'h0, exp}, {31'h0, hp_irq});
  endtask : irq_is
  task automatic reset_dut();
    arst_n <= 1'h0;
    idle(2);
    arst_n <= 1'h1;
    idle(4);
  endtask : reset_dut
  initial begin
    {arst_n, wr_en, rd_en, strap, link, addr, wr_data} = '0;
    impl = 1'h1;
    reset_dut();
    rd(SLOT_OFS);
    check("reset word", 32'h0040_03C0, word);
    // reserved bits must stay zero; power-off raises a command completion
    wr(SLOT_OFS, 32'hFFFF_FFFF);
    #1 check("pwr_off", 32'h1, {31'h0, pwr_off});
    irq_is(1'h1, 8);
    rd(SLOT_OFS);
    check("all ones word", 32'h0050_17FB, word);
    wr(SLOT_OFS, 32'h0010_17FB);
    irq_is(1'h0, 2);
    $display("test reserved and command done");
    for (int c = 1; c < 4; c++) begin
      wr(SLOT_OFS, 32'h0000_143B | (c << 6) | ((4 - c) << 8));
      #1 check("indicators", {22'h0, 2'h3, 2'(c), 2'(4 - c), 2'(c), 2'(4 - c)},
        {22'h0, attn_vld, pwr_vld, attn_code, pwr_code, attn_ind, pwr_ind});
    end
    idle(1);
    #1 check("msg pulse", 32'h0, {30'h0, attn_vld, pwr_vld});
    $display("test indicators");
    wr(SLOT_OFS, 32'h17FB);
    for (int i = 0; i < 4; i++) begin
      idle(1);
      case (i)
        0: slot_u.attn_button <= 1'h1;
        1: slot_u.power_fault <= 1'h1;
        2: slot_u.card_present <= 1'h0;
        default: link <= 1'h1;
      endcase
      irq_is(1'h1, 6);
      wr(SLOT_OFS, 32'h17FB);
      rd(SLOT_OFS);
      check("event flag", 32'h1, {31'h0, word[bits[i]]});
      wr(SLOT_OFS, 32'h17FB | (1 << bits[i]));
      irq_is(1'h0, 2);
    end
    $display("test events");
    @(posedge clk);
    slot_u.attn_button <= 1'h0;
    wr(SLOT_OFS, 32'h17DB);
    idle(4);
    slot_u.attn_button <= 1'h1;
    irq_is(1'h0, 6);
    wr(SLOT_OFS, 32'h17FB);
    irq_is(1'h1, 2);
    wr(SLOT_OFS, 32'h0001_17FB);
    slot_u.retention_latch_sensor <= 1'h1;
    idle(6);
    wr(SLOT_OFS, 32'h0004_17FB);
    rd(SLOT_OFS);
    check("latch bits", 32'h3, {30'h0, word[21], word[18]});
    $display("test mask and latch");
    check("presence", 32'h0, {31'h0, word[22]});
    @(posedge clk);
    impl <= 1'h0;
    rd(SLOT_OFS);
    check("presence no slot", 32'h1, {31'h0, word[22]});
    wr(8'hDC, 32'h0);
    rd(SLOT_OFS);
    check("ctl after stray write", 32'h17FB, {16'h0, word[15:0]});
    rd(8'hDC);
    check("unmapped read", 32'h0, word);
    // power-on request also completes a command
    wr(SLOT_OFS, 32'h0000_13FB);
    #1 check("pwr_off", 32'h0, {31'h0, pwr_off});
    irq_is(1'h1, 8);
    $display("test presence and unmapped");
    @(posedge clk);
    {slot_u.attn_button, slot_u.power_fault, slot_u.retention_latch_sensor} <= 3'h0;
    impl <= 1'h1;
    strap <= 1'h1;
    idle(6);
    reset_dut();
    rd(SLOT_OFS);
    check("strap reset word", 32'h0000_03C0, word);
    $display("test strap");
    finish_test();
  end
endmodule : tb_hpsc_slot_regs
